// File: inc/amlc_pkg.sv
package amlc_pkg;
    localparam int          CLK_HZ      = 10_000_000;
    localparam int          DM_RATE_HZ  = 48_000;
    localparam logic [7:0]  DM_DIV      = 8'(CLK_HZ / DM_RATE_HZ);

    // Samples and coefficients are signed with 23 fraction bits
    localparam int                 FRAC        = 23;
    localparam logic signed [31:0] UNITY       = 32'sh0080_0000;
    localparam logic signed [31:0] CLIP_CEIL   = 32'sh07ff_ffff;
    localparam logic signed [31:0] SMP_MAX     = 32'sh7fff_ffff;
    localparam logic signed [31:0] SMP_MIN     = 32'sh8000_0000;

    // Register offsets
    localparam logic [7:0] CH_CFG_FIRST = 8'h05;
    localparam logic [7:0] CH_CFG_LAST  = 8'h0c;
    localparam logic [7:0] MIX_FIRST    = 8'haa;
    localparam logic [7:0] MIX_LAST     = 8'hb1;
    localparam logic [7:0] GEN_CTRL     = 8'he0;
    localparam logic [7:0] DM_FRONT     = 8'he3;
    localparam logic [7:0] DM_CENTRE    = 8'he4;
    localparam logic [7:0] DM_LS_RIGHT  = 8'he5;
    localparam logic [7:0] DM_RS_RIGHT  = 8'he6;
    localparam logic [7:0] DM_LS_LEFT   = 8'he7;
    localparam logic [7:0] DM_RS_LEFT   = 8'he8;
    localparam logic [7:0] LIM_PRE      = 8'he9;
    localparam logic [7:0] LIM_POST     = 8'hea;

    // Field positions
    localparam int         CFG_RECOVER  = 7;
    localparam int         CFG_INVERT   = 4;
    localparam logic [7:0] CFG_MASK     = 8'h90;
    localparam int         GC_WO_BIT    = 3;
    localparam int         GC_SUPPLY_VOLUME_CONTROL      = 2;
    localparam int         GC_SIX_CH    = 1;
    localparam int         MIX_SLOT_W   = 4;
    localparam logic [11:0] MIX_MASK2   = 12'h0ff;
    localparam logic [11:0] MIX_MASK3   = 12'hfff;

    // Reset values
    localparam logic [7:0]         CFG_RST      = 8'h00;
    localparam logic [1:0]         GC_RST       = 2'h0;
    localparam logic signed [31:0] DM_FRONT_RST = 32'sh0029_0331;
    localparam logic signed [31:0] DM_CTR_RST   = 32'sh001c_fee9;
    localparam logic signed [31:0] DM_SUR_RST   = 32'shffe3_0117;

    typedef logic signed [31:0] amlc_smp_t;

    typedef struct packed {
        amlc_smp_t [7:0] ch;
    } amlc_frame_t;

    typedef struct packed {
        amlc_smp_t left;
        amlc_smp_t right;
    } amlc_stereo_t;
endpackage : amlc_pkg

// File: verilog/amlc_audio_post.sv
`timescale 1ns/10ps
// How it works
// [R1] Clip stage saturates at plus 24 dB
// [R2] Pre gain, clip, then post gain
// [R3] Downmix output held at 48 kHz
// [R4] Left is weighted front, centre, surround sum
// [R5] Right is weighted front, centre, surround sum
// [R6] Sources are input mixer channels 1,2,8,3,4
// [R7] Reset coefficients give the default fold
// [R8] Software sets matrix surround fold
// [R9] Software sets mono compatible fold
// [R10] Outputs 1-6 mix two, 7-8 three
// [R11] Pass-through maps channel n to n
// [R12] Software avoids channel mute when remapping
// [R13] Software keeps volume sum above -109 dB
// [R14] Config D7 selects fault recovery per channel
// [R15] Config D4 inverts the PWM output
// [R16] Headphones force default config on channels 1,2
// [R17] General control upper bits zero, D0 ignored
// [R18] D3 write-only, always zero
// [R19] D2 enables supply volume control
// [R20] D1 selects six or eight channels
// [R21] Subwoofer not a line output under SUPPLY_VOLUME_CONTROL
// [R22] Six-channel: 5,6 skip master volume, loudness
// [R23] Six-channel: 5,6 ignore the back-end fault
// [R24] Clip is symmetric, never wraps
module amlc_audio_post (
    input  wire logic                  mclk_in,
    input  wire logic                  srst_in,
    input  wire logic                  reg_wr_in,
    input  wire logic                  reg_rd_in,
    input  wire logic [7:0]            reg_addr_in,
    input  wire logic [31:0]           reg_wdata_in,
    output logic      [31:0]           reg_rdata_out,
    input  wire amlc_pkg::amlc_frame_t proc_smp_in,
    input  wire logic                  proc_valid_in,
    input  wire amlc_pkg::amlc_frame_t mix_smp_in,
    input  wire logic                  mix_valid_in,
    input  wire logic                  backend_fault_n_in,
    input  wire logic                  headphone_sel_in,
    output amlc_pkg::amlc_frame_t      pwm_smp_out,
    output logic                       pwm_valid_out,
    output logic      [7:0]            pwm_invert_out,
    output logic      [7:0]            chan_hold_out,
    output logic      [7:0]            master_vol_bypass_out,
    output logic                       supply_volume_control_out,
    output logic                       six_channel_out,
    output logic                       sub_lineout_ok_out,
    output amlc_pkg::amlc_stereo_t     i2s_smp_out,
    output logic                       i2s_valid_out
);

    function automatic logic signed [63:0] amlc_mul(input logic signed [31:0] a,
                                                    input logic signed [31:0] b);
        logic signed [63:0] p;
        p = 64'(a) * 64'(b);
        return p >>> amlc_pkg::FRAC;
    endfunction : amlc_mul

    function automatic amlc_pkg::amlc_smp_t amlc_sat(input logic signed [63:0] v);
        if (v > 64'(amlc_pkg::SMP_MAX)) return amlc_pkg::SMP_MAX;
        if (v < 64'(amlc_pkg::SMP_MIN)) return amlc_pkg::SMP_MIN;
        return v[31:0];
    endfunction : amlc_sat

    // Negative limit mirrors the ceiling
    function automatic amlc_pkg::amlc_smp_t amlc_clip(input logic signed [63:0] v);
        if (v > 64'(amlc_pkg::CLIP_CEIL)) return amlc_pkg::CLIP_CEIL;       // [R1]
        if (v < -64'(amlc_pkg::CLIP_CEIL)) return -amlc_pkg::CLIP_CEIL;     // [R24]
        return v[31:0];
    endfunction : amlc_clip

    logic [7:0]          cfg_r [8];
    logic [11:0]         mix_r [8];
    logic [1:0]          gc_r;
    amlc_pkg::amlc_smp_t front_r, centre_r, ls_right_r, rs_right_r, ls_left_r, rs_left_r;
    amlc_pkg::amlc_smp_t pre_r, post_r;
    logic [31:0]         rd_nxt;

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            for (int c = 0; c < 8; c++) begin
                cfg_r[c] <= amlc_pkg::CFG_RST;
                mix_r[c] <= {8'h00, 1'b1, 3'(c)};
            end
        end else if (reg_wr_in) begin
            for (int c = 0; c < 8; c++) begin
                if (reg_addr_in == amlc_pkg::CH_CFG_FIRST + 8'(c)) begin
                    cfg_r[c] <= reg_wdata_in[7:0] & amlc_pkg::CFG_MASK;
                end
                if (reg_addr_in == amlc_pkg::MIX_FIRST + 8'(c)) begin
                    mix_r[c] <= reg_wdata_in[11:0] &
                                ((c < 6) ? amlc_pkg::MIX_MASK2 : amlc_pkg::MIX_MASK3); // [R10]
                end
            end
        end
    end

    // D3 is not stored and D0, D31-D4 are dropped
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            gc_r <= amlc_pkg::GC_RST;
        end else if (reg_wr_in && reg_addr_in == amlc_pkg::GEN_CTRL) begin
            gc_r <= reg_wdata_in[amlc_pkg::GC_SUPPLY_VOLUME_CONTROL:amlc_pkg::GC_SIX_CH];   // [R17]
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            front_r    <= amlc_pkg::DM_FRONT_RST;                          // [R7]
            centre_r   <= amlc_pkg::DM_CTR_RST;
            ls_right_r <= amlc_pkg::DM_SUR_RST;
            rs_right_r <= amlc_pkg::DM_SUR_RST;
            ls_left_r  <= amlc_pkg::DM_SUR_RST;
            rs_left_r  <= amlc_pkg::DM_SUR_RST;
            pre_r      <= amlc_pkg::UNITY;
            post_r     <= amlc_pkg::UNITY;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                amlc_pkg::DM_FRONT:    front_r    <= reg_wdata_in;
                amlc_pkg::DM_CENTRE:   centre_r   <= reg_wdata_in;
                amlc_pkg::DM_LS_RIGHT: ls_right_r <= reg_wdata_in;
                amlc_pkg::DM_RS_RIGHT: rs_right_r <= reg_wdata_in;
                amlc_pkg::DM_LS_LEFT:  ls_left_r  <= reg_wdata_in;
                amlc_pkg::DM_RS_LEFT:  rs_left_r  <= reg_wdata_in;
                amlc_pkg::LIM_PRE:     pre_r      <= reg_wdata_in;
                amlc_pkg::LIM_POST:    post_r     <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        for (int c = 0; c < 8; c++) begin
            if (reg_addr_in == amlc_pkg::CH_CFG_FIRST + 8'(c)) rd_nxt = {24'h0, cfg_r[c]};
            if (reg_addr_in == amlc_pkg::MIX_FIRST + 8'(c)) rd_nxt = {20'h0, mix_r[c]};
        end
        unique case (reg_addr_in)
            amlc_pkg::GEN_CTRL:    rd_nxt = {29'h0, gc_r, 1'b0};           // [R18]
            amlc_pkg::DM_FRONT:    rd_nxt = front_r;
            amlc_pkg::DM_CENTRE:   rd_nxt = centre_r;
            amlc_pkg::DM_LS_RIGHT: rd_nxt = ls_right_r;
            amlc_pkg::DM_RS_RIGHT: rd_nxt = rs_right_r;
            amlc_pkg::DM_LS_LEFT:  rd_nxt = ls_left_r;
            amlc_pkg::DM_RS_LEFT:  rd_nxt = rs_left_r;
            amlc_pkg::LIM_PRE:     rd_nxt = pre_r;
            amlc_pkg::LIM_POST:    rd_nxt = post_r;
            default: ;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_nxt;
        end
    end

    // Pins from outside the clock domain
    logic [1:0] fault_sync_r;
    logic [1:0] hp_sync_r;
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            fault_sync_r <= 2'b11;
            hp_sync_r    <= 2'b00;
        end else begin
            fault_sync_r <= {fault_sync_r[0], backend_fault_n_in};
            hp_sync_r    <= {hp_sync_r[0], headphone_sel_in};
        end
    end
    wire logic fault_s = ~fault_sync_r[1];
    wire logic hp_s    = hp_sync_r[1];
    wire logic six_ch  = gc_r[0];
    wire logic supply_volume_control_en = gc_r[1];

    logic [7:0] eff_cfg [8];
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            eff_cfg[c] = (hp_s && c < 2) ? amlc_pkg::CFG_RST : cfg_r[c];   // [R16]
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pwm_invert_out        <= 8'h00;
            chan_hold_out         <= 8'h00;
            master_vol_bypass_out <= 8'h00;
        end else begin
            for (int c = 0; c < 8; c++) begin
                pwm_invert_out[c] <= eff_cfg[c][amlc_pkg::CFG_INVERT];     // [R15]
                chan_hold_out[c]  <= fault_s && eff_cfg[c][amlc_pkg::CFG_RECOVER] &&
                                     !(six_ch && (c == 4 || c == 5));      // [R14] [R23]
                master_vol_bypass_out[c] <= six_ch && (c == 4 || c == 5);  // [R22]
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            supply_volume_control_out <= 1'b0;
            six_channel_out           <= 1'b0;
            sub_lineout_ok_out        <= 1'b1;
        end else begin
            supply_volume_control_out <= supply_volume_control_en;                          // [R19]
            six_channel_out           <= six_ch;                           // [R20]
            sub_lineout_ok_out        <= !supply_volume_control_en;                         // [R21]
        end
    end

    // Limiter: pre gain and clip, then post gain one cycle later
    amlc_pkg::amlc_frame_t clip_r, lim_r;
    logic                  clip_v_r, lim_v_r;
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            clip_r   <= '0;
            lim_r    <= '0;
            clip_v_r <= 1'b0;
            lim_v_r  <= 1'b0;
        end else begin
            clip_v_r <= proc_valid_in;
            lim_v_r  <= clip_v_r;
            for (int c = 0; c < 8; c++) begin
                if (proc_valid_in) begin
                    clip_r.ch[c] <= amlc_clip(amlc_mul(proc_smp_in.ch[c], pre_r));  // [R2]
                end
                if (clip_v_r) begin
                    lim_r.ch[c] <= amlc_sat(amlc_mul(clip_r.ch[c], post_r));        // [R2]
                end
            end
        end
    end

    // Output crossbar; a disabled slot contributes nothing
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pwm_smp_out   <= '0;
            pwm_valid_out <= 1'b0;
        end else begin
            pwm_valid_out <= lim_v_r;
            if (lim_v_r) begin
                for (int o = 0; o < 8; o++) begin
                    logic signed [63:0] acc;
                    acc = 64'sh0;
                    for (int k = 0; k < 3; k++) begin
                        if (mix_r[o][k*amlc_pkg::MIX_SLOT_W + 3]) begin
                            acc = acc + 64'(lim_r.ch[mix_r[o][k*amlc_pkg::MIX_SLOT_W +: 3]]);
                        end
                    end
                    pwm_smp_out.ch[o] <= amlc_sat(acc);                    // [R10] [R11]
                end
            end
        end
    end

    // Stereo downmix from the input mixer channels
    wire amlc_pkg::amlc_smp_t src_l  = mix_smp_in.ch[0];                   // [R6]
    wire amlc_pkg::amlc_smp_t src_r  = mix_smp_in.ch[1];
    wire amlc_pkg::amlc_smp_t src_ls = mix_smp_in.ch[2];
    wire amlc_pkg::amlc_smp_t src_rs = mix_smp_in.ch[3];
    wire amlc_pkg::amlc_smp_t src_c  = mix_smp_in.ch[7];
    amlc_pkg::amlc_stereo_t dm_r;
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            dm_r <= '0;
        end else if (mix_valid_in) begin
            dm_r.left  <= amlc_sat(amlc_mul(front_r, src_l) + amlc_mul(centre_r, src_c) +
                                   amlc_mul(ls_left_r, src_ls) +
                                   amlc_mul(rs_left_r, src_rs));           // [R4]
            dm_r.right <= amlc_sat(amlc_mul(front_r, src_r) + amlc_mul(centre_r, src_c) +
                                   amlc_mul(ls_right_r, src_ls) +
                                   amlc_mul(rs_right_r, src_rs));          // [R5]
        end
    end

    // Fixed-rate resampler: zero-order hold of the latest mix at each 48 kHz tick.
    // Cheap, but it aliases; an interpolator would cost a filter bank.
    logic [7:0] rate_cnt_r;
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rate_cnt_r    <= 8'h00;
            i2s_smp_out   <= '0;
            i2s_valid_out <= 1'b0;
        end else begin
            i2s_valid_out <= 1'b0;
            if (rate_cnt_r == amlc_pkg::DM_DIV - 8'h01) begin
                rate_cnt_r    <= 8'h00;
                i2s_smp_out   <= dm_r;                                     // [R3]
                i2s_valid_out <= 1'b1;
            end else begin
                rate_cnt_r <= rate_cnt_r + 8'h01;
            end
        end
    end

    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    logic       clip_ok;
    logic [7:0] gap_r;
    logic       seen_r;
    always_comb begin
        clip_ok = 1'b1;
        for (int c = 0; c < 8; c++) begin
            if (clip_r.ch[c] > amlc_pkg::CLIP_CEIL || clip_r.ch[c] < -amlc_pkg::CLIP_CEIL)
                clip_ok = 1'b0;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            gap_r  <= 8'h00;
            seen_r <= 1'b0;
        end else begin
            gap_r  <= i2s_valid_out ? 8'h00 : gap_r + 8'h01;
            seen_r <= seen_r | i2s_valid_out;
        end
    end

    clip_bound_a: assert property (clip_ok)                                // [R1] [R24]
        else $error("clip stage exceeds ceiling");
    lim_post_a: assert property (clip_v_r |=> lim_r.ch[0] ==               // [R2]
            amlc_sat(amlc_mul($past(clip_r.ch[0]), $past(post_r))))
        else $error("post gain result wrong");
    dm_rate_a: assert property (i2s_valid_out && seen_r |->                // [R3]
            gap_r == amlc_pkg::DM_DIV - 8'h01)
        else $error("serial output rate wrong");
    dm_left_a: assert property (mix_valid_in |=> dm_r.left ==              // [R4] [R6]
            amlc_sat(amlc_mul($past(front_r), $past(mix_smp_in.ch[0])) +
                     amlc_mul($past(centre_r), $past(mix_smp_in.ch[7])) +
                     amlc_mul($past(ls_left_r), $past(mix_smp_in.ch[2])) +
                     amlc_mul($past(rs_left_r), $past(mix_smp_in.ch[3]))))
        else $error("left downmix wrong");
    dm_right_a: assert property (mix_valid_in |=> dm_r.right ==            // [R5] [R6]
            amlc_sat(amlc_mul($past(front_r), $past(mix_smp_in.ch[1])) +
                     amlc_mul($past(centre_r), $past(mix_smp_in.ch[7])) +
                     amlc_mul($past(ls_right_r), $past(mix_smp_in.ch[2])) +
                     amlc_mul($past(rs_right_r), $past(mix_smp_in.ch[3]))))
        else $error("right downmix wrong");
    coef_reset_a: assert property (@(posedge mclk_in) $fell(srst_in) |->   // [R7]
            front_r == amlc_pkg::DM_FRONT_RST && rs_left_r == amlc_pkg::DM_SUR_RST)
        else $error("downmix defaults wrong");
    pass_thru_a: assert property (lim_v_r && mix_r[6] == 12'h00e |=>       // [R11]
            pwm_smp_out.ch[6] == $past(lim_r.ch[6]))
        else $error("pass-through mapping broken");
    fault_hold_a: assert property (fault_s && eff_cfg[2][7] |=> chan_hold_out[2])  // [R14]
        else $error("channel did not enter recovery");
    six_ignore_a: assert property (six_ch |=> !chan_hold_out[4] && !chan_hold_out[5]
            && master_vol_bypass_out[5])                                   // [R22] [R23]
        else $error("six-channel handling wrong");
    invert_out_a: assert property (eff_cfg[3][4] |=> pwm_invert_out[3])    // [R15]
        else $error("invert flag not applied");
    hp_default_a: assert property (hp_s |=> pwm_invert_out[1:0] == 2'b00 &&
            chan_hold_out[1:0] == 2'b00)                                   // [R16]
        else $error("headphone default not forced");
    gc_apply_a: assert property (reg_wr_in && reg_addr_in == amlc_pkg::GEN_CTRL |=> ##1
            supply_volume_control_out == $past(reg_wdata_in[2], 2) &&
            six_channel_out == $past(reg_wdata_in[1], 2) &&
            sub_lineout_ok_out != supply_volume_control_out)               // [R19] [R20] [R21]
        else $error("general control not applied");

    dm_out_c:   cover property (i2s_valid_out && dm_r.left != 32'sh0);
    hold_c:     cover property (fault_s ##1 chan_hold_out != 8'h00);
    hp_c:       cover property (hp_s && cfg_r[0] != amlc_pkg::CFG_RST);
    clip_hit_c: cover property (clip_r.ch[0] == amlc_pkg::CLIP_CEIL);

endmodule : amlc_audio_post

// File: test/amlc_far_model.sv
`timescale 1ns/10ps
// Power stage stand-in: fault pin and frame count
module amlc_far_model (
    input  wire logic        mclk_in,
    input  wire logic        fault_req_in,
    input  wire logic        pwm_valid_in,
    output logic             backend_fault_n_out,
    output logic      [15:0] frames_out
);
    initial begin
        backend_fault_n_out = 1'b1;
        frames_out = 16'h0000;
    end
    always @(negedge mclk_in) backend_fault_n_out <= !fault_req_in;
    always @(posedge mclk_in) if (pwm_valid_in) frames_out <= frames_out + 16'h0001;
endmodule : amlc_far_model

// File: test/amlc_audio_post_tb_top.sv
`timescale 1ns/10ps
module amlc_audio_post_tb_top;
    typedef logic [255:0] amlc_wide_t;
    typedef logic signed [31:0] amlc_s_t;
    logic                   mclk_in = 1'b0;
    logic                   srst_in = 1'b1;
    logic                   reg_wr_in = 1'b0;
    logic                   reg_rd_in = 1'b0;
    logic [7:0]             reg_addr_in = 8'h00;
    logic [31:0]            reg_wdata_in = 32'h0;
    logic [31:0]            reg_rdata_out;
    amlc_pkg::amlc_frame_t  proc_smp_in = '0;
    amlc_pkg::amlc_frame_t  mix_smp_in = '0;
    amlc_pkg::amlc_frame_t  pwm_smp_out;
    amlc_pkg::amlc_stereo_t i2s_smp_out;
    logic                   proc_valid_in = 1'b0;
    logic                   mix_valid_in = 1'b0;
    logic                   headphone_sel_in = 1'b0;
    logic                   fault_req = 1'b0;
    logic                   backend_fault_n_in;
    logic                   pwm_valid_out;
    logic                   i2s_valid_out;
    logic [7:0]             pwm_invert_out;
    logic [7:0]             chan_hold_out;
    logic [7:0]             master_vol_bypass_out;
    logic                   supply_volume_control_out;
    logic                   six_channel_out;
    logic                   sub_lineout_ok_out;
    logic [15:0]            frames;
    logic [31:0]            rng = 32'hda75;
    logic                   rd_q1 = 1'b0;
    logic                   rd_q2 = 1'b0;
    int                     num_errors = 0;
    int                     n_tests = 0;
    int                     cyc = 0;
    int                     last_tick = 0;
    amlc_wide_t             rq[$];
    amlc_wide_t             pq[$];
    amlc_wide_t             iq[$];
    amlc_pkg::amlc_frame_t  f;
    logic [7:0]             cf[8];
    logic [7:0]             inv;
    logic [7:0]             rec;

    amlc_audio_post dut (.mclk_in(mclk_in), .srst_in(srst_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .proc_smp_in(proc_smp_in),
        .proc_valid_in(proc_valid_in), .mix_smp_in(mix_smp_in), .mix_valid_in(mix_valid_in),
        .backend_fault_n_in(backend_fault_n_in), .headphone_sel_in(headphone_sel_in),
        .pwm_smp_out(pwm_smp_out), .pwm_valid_out(pwm_valid_out),
        .pwm_invert_out(pwm_invert_out), .chan_hold_out(chan_hold_out),
        .master_vol_bypass_out(master_vol_bypass_out),
        .supply_volume_control_out(supply_volume_control_out),
        .six_channel_out(six_channel_out), .sub_lineout_ok_out(sub_lineout_ok_out),
        .i2s_smp_out(i2s_smp_out), .i2s_valid_out(i2s_valid_out));
    amlc_far_model stage (.mclk_in(mclk_in), .fault_req_in(fault_req),
        .pwm_valid_in(pwm_valid_out), .backend_fault_n_out(backend_fault_n_in),
        .frames_out(frames));

    always #50 mclk_in = ~mclk_in;

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    function automatic logic signed [63:0] mul(amlc_s_t x, amlc_s_t c);
        logic signed [63:0] a = x;
        logic signed [63:0] b = c;
        return (a * b) >>> amlc_pkg::FRAC;
    endfunction : mul

    function automatic amlc_s_t lim(amlc_s_t x, amlc_s_t pre);
        logic signed [63:0] p;
        p = mul(x, pre);
        if (p > amlc_pkg::CLIP_CEIL) p = amlc_pkg::CLIP_CEIL;
        if (p < -amlc_pkg::CLIP_CEIL) p = -amlc_pkg::CLIP_CEIL;
        return p[31:0];
    endfunction : lim

    task automatic check(string nm, amlc_wide_t seen, amlc_wide_t exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(negedge mclk_in);
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge mclk_in);
        reg_wr_in = 1'b0;
    endtask : wr

    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(negedge mclk_in);
        reg_rd_in = 1'b1;
        reg_addr_in = a;
        rq.push_back(amlc_wide_t'(e));
        @(negedge mclk_in);
        reg_rd_in = 1'b0;
        @(negedge mclk_in);
    endtask : rd

    task automatic send(amlc_pkg::amlc_frame_t x, amlc_s_t pre, bit mx);
        amlc_pkg::amlc_frame_t e;
        @(negedge mclk_in);
        proc_smp_in = x;
        proc_valid_in = 1'b1;
        for (int c = 0; c < 8; c++) e.ch[c] = lim(x.ch[c], pre);
        if (mx) begin
            e.ch[7] = e.ch[0] + e.ch[1] + e.ch[2];
            e.ch[0] = e.ch[1] + e.ch[2];
        end
        pq.push_back(e);
        @(negedge mclk_in);
        proc_valid_in = 1'b0;
    endtask : send

    task automatic dmix();
        amlc_s_t k[6];
        amlc_pkg::amlc_stereo_t s;
        amlc_pkg::amlc_frame_t m;
        logic [31:0] r;
        for (int i = 0; i < 6; i++) begin
            r = xs();
            k[i] = amlc_pkg::UNITY * (32'(r[1:0]) - 32'sd2);
            wr(amlc_pkg::DM_FRONT + 8'(i), k[i]);
            rd(amlc_pkg::DM_FRONT + 8'(i), k[i]);
        end
        for (int c = 0; c < 8; c++) m.ch[c] = $signed(xs()) >>> 16;
        s.left = 32'(mul(m.ch[0], k[0]) + mul(m.ch[7], k[1]) + mul(m.ch[2], k[4])
            + mul(m.ch[3], k[5]));
        s.right = 32'(mul(m.ch[1], k[0]) + mul(m.ch[7], k[1]) + mul(m.ch[2], k[2])
            + mul(m.ch[3], k[3]));
        @(negedge mclk_in iff i2s_valid_out);
        @(negedge mclk_in);
        mix_smp_in = m;
        mix_valid_in = 1'b1;
        iq.push_back(amlc_wide_t'(s));
        @(negedge mclk_in);
        mix_valid_in = 1'b0;
    endtask : dmix

    task automatic ctl(logic [7:0] iv, logic [7:0] hd, logic [7:0] bp, logic [2:0] md);
        repeat (5) @(negedge mclk_in);
        check("ctl", amlc_wide_t'({pwm_invert_out, chan_hold_out, master_vol_bypass_out,
            supply_volume_control_out, six_channel_out, sub_lineout_ok_out}),
            amlc_wide_t'({iv, hd, bp, md}));
    endtask : ctl

    always @(posedge mclk_in) begin
        rd_q1 <= reg_rd_in;
        rd_q2 <= rd_q1;
        cyc <= cyc + 1;
    end

    always @(negedge mclk_in) begin
        if (rd_q2) check("rdata", amlc_wide_t'(reg_rdata_out), rq.pop_front());
        if (pwm_valid_out) check("pwm", pwm_smp_out, pq.pop_front());
        if (i2s_valid_out) begin
            if (last_tick != 0) check("period", amlc_wide_t'(cyc - last_tick),
                amlc_wide_t'(amlc_pkg::DM_DIV));
            last_tick = cyc;
            if (iq.size() > 0) check("i2s", amlc_wide_t'(i2s_smp_out), iq.pop_front());
        end
        if (cyc > 20000) begin
            num_errors++;
            close_out();
        end
    end

    initial begin
        repeat (10) @(negedge mclk_in);
        srst_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        rd(amlc_pkg::LIM_PRE, amlc_pkg::UNITY);
        rd(amlc_pkg::LIM_POST, amlc_pkg::UNITY);
        rd(amlc_pkg::DM_FRONT, amlc_pkg::DM_FRONT_RST);
        rd(amlc_pkg::DM_CENTRE, amlc_pkg::DM_CTR_RST);
        for (int i = 0; i < 4; i++) rd(amlc_pkg::DM_LS_RIGHT + 8'(i), amlc_pkg::DM_SUR_RST);
        for (int i = 0; i < 8; i++) rd(amlc_pkg::CH_CFG_FIRST + 8'(i), 32'h0);
        wr(8'hf0, 32'hffff_ffff);
        rd(8'hf0, 32'h0);
        rd(amlc_pkg::GEN_CTRL, 32'h0);
        ctl(8'h00, 8'h00, 8'h00, 3'b001);
        $display("reset values done");
        f.ch = {32'sh0, 32'sh0, amlc_pkg::SMP_MIN, amlc_pkg::SMP_MAX,
            -amlc_pkg::CLIP_CEIL - 32'sd1, -amlc_pkg::CLIP_CEIL,
            amlc_pkg::CLIP_CEIL + 32'sd1, amlc_pkg::CLIP_CEIL};
        send(f, amlc_pkg::UNITY, 1'b0);
        wr(amlc_pkg::LIM_PRE, amlc_pkg::UNITY <<< 1);
        wr(amlc_pkg::MIX_FIRST, 32'h0000_00a9);
        wr(amlc_pkg::MIX_LAST, 32'h0000_0a98);
        for (int n = 0; n < 6; n++) begin
            for (int c = 0; c < 8; c++) f.ch[c] = $signed(xs()) >>> (n * 4);
            send(f, amlc_pkg::UNITY <<< 1, 1'b1);
        end
        repeat (6) @(negedge mclk_in);
        check("frames", amlc_wide_t'(frames), amlc_wide_t'(16'd7));
        $display("limiter and crossbar done");
        dmix();
        dmix();
        repeat (215) @(negedge mclk_in);
        $display("downmix done");
        for (int i = 0; i < 8; i++) begin
            cf[i] = 8'(xs());
            inv[i] = cf[i][amlc_pkg::CFG_INVERT];
            rec[i] = cf[i][amlc_pkg::CFG_RECOVER];
            wr(amlc_pkg::CH_CFG_FIRST + 8'(i), {24'h0, cf[i]});
            rd(amlc_pkg::CH_CFG_FIRST + 8'(i), {24'h0, cf[i] & amlc_pkg::CFG_MASK});
        end
        ctl(inv, 8'h00, 8'h00, 3'b001);
        fault_req = 1'b1;
        ctl(inv, rec, 8'h00, 3'b001);
        headphone_sel_in = 1'b1;
        ctl(inv & 8'hfc, rec & 8'hfc, 8'h00, 3'b001);
        headphone_sel_in = 1'b0;
        wr(amlc_pkg::GEN_CTRL, 32'h0000_0003);
        rd(amlc_pkg::GEN_CTRL, 32'h0000_0002);
        ctl(inv, rec & 8'hcf, 8'h30, 3'b011);
        wr(amlc_pkg::GEN_CTRL, 32'h0000_0004);
        rd(amlc_pkg::GEN_CTRL, 32'h0000_0004);
        ctl(inv, rec, 8'h00, 3'b100);
        fault_req = 1'b0;
        ctl(inv, 8'h00, 8'h00, 3'b100);
        $display("configuration done");
        close_out();
    end
endmodule : amlc_audio_post_tb_top
